// ==== dv/pin_state_sva.sv ====
// assertions on the ports of the pin-state block
`timescale 1ns/1ps
`default_nettype none
module pin_state_sva #(
	parameter NPINS    = 16,
	parameter MAIN_OSC = 16'h0003,
	parameter SUB_OSC  = 16'h000c,
	parameter LCD_PINS = 16'hf000,
	parameter CMP_OUT  = 16'h0020
) (
	input wire logic             pclk,       // clock
	input wire logic             presetn,    // reset, low
	input wire logic             ce,         // clock enable
	input wire logic             psel,       // apb select
	input wire logic             penable,    // apb enable
	input wire logic             pready,     // apb ready
	input wire logic             pslverr,    // apb error
	input wire logic             stop_mode,  // stop
	input wire logic             watch_mode, // watch
	input wire logic             cmp_result, // comparator
	input wire logic [NPINS-1:0] pin_out,    // pad level
	input wire logic [NPINS-1:0] pin_oe,     // pad enable
	input wire logic [NPINS-1:0] pin_in_en,  // input gate
	input wire logic [NPINS-1:0] port_in,    // gated input
	input wire logic [NPINS-1:0] osc_active, // oscillation
	input wire logic             wake        // wake pulse
);
	wire logic sb;
	assign sb = stop_mode | watch_mode;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
////////////////////////////////////////////////////////////////
	a_reset_state: assert property (disable iff (1'b0) !presetn |->
		pin_oe == '0 && pin_in_en == ~LCD_PINS && osc_active == (MAIN_OSC | SUB_OSC)) else $error("reset pin state");
	a_ready_ce: assert property (pready == ce) else $error("pready differs from ce");
	a_err_phase: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
	a_wake_once: assert property (wake |=> !wake)
		else $error("wake longer than one cycle");
	a_wake_sby: assert property (wake |-> sb || $past(sb))
		else $error("wake outside standby");
	a_port_block: assert property (sb && ce |=> port_in == '0)
		else $error("input not blocked");
	a_gate_shut: assert property (sb && ce |=> (pin_in_en & (CMP_OUT | LCD_PINS)) == '0)
		else $error("input gate open in standby");
	a_cmp_live: assert property (sb && ce |=>
		(pin_oe & CMP_OUT) == '0 || ((pin_out & CMP_OUT) != '0) == $past(cmp_result)) else $error("comparator pin frozen");
	a_hold_pins: assert property (sb && ce ##1 sb && ce |=>
		$stable(pin_oe) && $stable(pin_out & pin_oe & ~CMP_OUT)) else $error("held pin moved");
	a_osc_stop: assert property (sb && ce |=> (osc_active & (MAIN_OSC | SUB_OSC)) == '0)
		else $error("oscillator active in standby");
	a_osc_no_drive: assert property ((pin_oe & osc_active) == '0)
		else $error("oscillator pin driven");
	c_wake: cover property (sb ##1 wake);
	c_err: cover property (pslverr);
	c_exit: cover property ($fell(sb));
endmodule
bind standby_pin_state_control pin_state_sva #(.NPINS(NPINS), .MAIN_OSC(MAIN_OSC), .SUB_OSC(SUB_OSC),
	.LCD_PINS(LCD_PINS), .CMP_OUT(CMP_OUT)) u_sva (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .stop_mode(stop_mode), .watch_mode(watch_mode),
	.cmp_result(cmp_result), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in_en(pin_in_en), .port_in(port_in),
	.osc_active(osc_active), .wake(wake));
`default_nettype wire

// ==== dv/standby_pin_state_control_tb.sv ====
// self-checking bench for the pin-state block
`timescale 1ns/1ps
`default_nettype none
`include "pin_state_defines.vh"
module standby_pin_state_control_tb;
	logic        pclk = 0, presetn = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, rerr;
	logic        stop_mode = 0, watch_mode = 0, cmp_result = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, rdat;
	logic [15:0] periph_en = 16'h0100, periph_oe = 16'h0100, periph_out = '0;
	logic [15:0] pin_in = '0; // pads always driven, never floating
	wire logic [31:0] prdata;
	wire logic        pready, pslverr, irq, rst_pin_in, wake;
	wire logic [15:0] pin_out, pin_oe, pin_pullup, pin_in_en, port_in, extint_in, analog_en, osc_active;
	int          err_count = 0, cmp_count = 0;
	standby_pin_state_control dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .irq, .stop_mode, .watch_mode, .periph_en, .periph_oe, .periph_out, .cmp_result,
		.pin_in, .pin_out, .pin_oe, .pin_pullup, .pin_in_en, .port_in, .extint_in, .analog_en, .osc_active,
		.rst_pin_in, .wake);
	initial forever #20 pclk = ~pclk;
////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// holds the request until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			tally_and_finish;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(0, a, 32'h0);
		chk(rdat, exp);
	endtask
	// outputs lag their cause by at most three edges
	task automatic settle;
		repeat (4) @(posedge pclk);
	endtask
	task automatic wait_wake;
		int n;
		n = 0;
		while (wake !== 1'b1 && n < 12) begin
			@(posedge pclk);
			n++;
		end
		chk({31'h0, wake}, 32'h1);
	endtask
////////////////////////////////////////////////////////////////
	initial begin
		// a real falling edge, so the async reset acts before the first clock
		presetn <= 0;
		repeat (4) @(posedge pclk);
		chk({pin_oe, pin_in_en}, {16'h0000, 16'h0fff});
		chk({pin_out, osc_active}, {16'h0000, 16'h000f});
		repeat (4) @(posedge pclk);
		presetn <= 1;
		rd(`OFS_STANDBY_CTRL, 32'h08);
		apb(0, 12'h024, 32'h0);
		chk({rerr, rdat[30:0]}, 32'h80000000);
		wr(`OFS_DIRECTION, 32'hffff);
		wr(`OFS_DATA_OUT, 32'ha5a5);
		wr(`OFS_PERIPH_SEL, 32'h0100);
		wr(`OFS_PULLUP, 32'h00f0);
		wr(`OFS_EXTINT_EN, 32'h0100);
		cmp_result <= 1;
		settle;
		chk({pin_oe, pin_out & 16'hffcf}, {16'hffef, 16'ha485});
		stop_mode <= 1;
		settle;
		wr(`OFS_DATA_OUT, 32'h5a5a);
		cmp_result <= 0;
		pin_in <= 16'h0300;
		wait_wake;
		settle;
		chk({pin_oe, pin_out & 16'hffef}, {16'hffef, 16'ha485});
		chk({port_in, extint_in}, {16'h0000, 16'h0100});
		rd(`OFS_INT_STATUS, 32'h9);
		chk({15'h0, irq, analog_en}, {16'h0000, 16'h0040});
		wr(`OFS_INT_MASK, 32'h8);
		settle;
		chk({31'h0, irq}, 32'h1);
		wr(`OFS_INT_STATUS, 32'h9);
		settle;
		chk({31'h0, irq}, 32'h0);
		stop_mode <= 0;
		settle;
		chk({pin_out & 16'hffcf, port_in & 16'h0f00}, {16'h5a4a, 16'h0300});
		rd(`OFS_INT_STATUS, 32'h2);
		wr(`OFS_INT_STATUS, 32'hf);
		wr(`OFS_STANDBY_CTRL, 32'h1f);
		pin_in <= 16'h0380;
		settle;
		watch_mode <= 1;
		settle;
		chk({pin_oe, pin_pullup}, {16'h0000, 16'h00f0});
		chk({port_in, osc_active}, 32'h0);
		pin_in <= 16'h0310;
		wait_wake;
		settle;
		chk({31'h0, rst_pin_in}, 32'h1);
		rd(`OFS_INT_STATUS, 32'h5);
		watch_mode <= 0;
		settle;
		chk({pin_oe, osc_active}, {16'hffe0, 16'h000f});
		ce <= 0;
		pin_in <= 16'h0000;
		repeat (4) @(posedge pclk);
		chk({15'h0, pready, port_in}, {16'h0000, 16'h0300});
		ce <= 1;
		settle;
		chk({16'h0, port_in}, 32'h0);
		tally_and_finish;
	end
	initial begin
		repeat (5000) @(posedge pclk);
		err_count++;
		tally_and_finish;
	end
endmodule
`default_nettype wire

// ==== rtl/pin_state_cell.v ====
// per-pin driver and input-gate selection for run, sleep, stop and watch
`timescale 1ns/1ps
`default_nettype none

module pin_state_cell (
	input  wire standby,     // stop or watch mode active
	input  wire pin_state_select,         // pin_state_select
	input  wire osc_ded,     // pin owned by an enabled oscillator
	input  wire rst_ded,     // pin owned by the reset input
	input  wire is_cmp_out,  // pin is comparator_out_pin
	input  wire is_extint,   // pin carries an external interrupt
	input  wire extint_en,   // that channel's request enabled
	input  wire is_cmp_in,   // pin is comparator_in_pin
	input  wire is_scl,      // pin is the i2c clock
	input  wire i2c_wake_en, // i2c standby wakeup enabled
	input  wire norm_oe,     // run-mode output enable
	input  wire norm_out,    // run-mode output level
	input  wire held_oe,     // enable captured at standby entry
	input  wire held_out,    // level captured at standby entry
	input  wire cmp_result,  // live comparator output
	input  wire pu_set,      // pull-up setting
	input  wire pin_in,      // synchronised pin level
	output reg  oe,          // pad output enable
	output reg  out,         // pad output level
	output wire pu,          // pad pull-up enable
	output reg  in_en,       // digital input gate open
	output wire port_in,     // level seen by internal logic
	output wire extint_in,   // level to the interrupt detector
	output wire analog_en,   // analog path to comparator open
	output wire scl_in,      // level to the i2c wake detector
	output wire osc_act,     // oscillation input active
	output wire rst_in       // level to the reset input
);

	always @* begin
		oe    = 1'b0;
		out   = 1'b0;
		in_en = 1'b0;
		if (osc_ded || rst_ded) begin
			in_en = 1'b0;
		end else if (standby) begin
			if (!pin_state_select) begin
				oe  = held_oe;
				out = is_cmp_out ? cmp_result : held_out;
			end
		end else begin
			oe    = norm_oe;
			out   = norm_out;
			in_en = 1'b1;
		end
	end

	// blocked inputs read low, also when floated
	assign port_in   = in_en & pin_in;
	assign extint_in = is_extint & ~osc_ded & ~rst_ded & (~standby | extint_en) & pin_in;
	assign analog_en = is_cmp_in & ~osc_ded & ~rst_ded;
	assign scl_in    = is_scl & ~osc_ded & ~rst_ded & (~standby | i2c_wake_en) & pin_in;
	// pull-up stays connected unless the pin drives low or an enabled oscillator owns it
	assign pu        = pu_set & ~osc_ded & ~(oe & ~out);
	assign osc_act   = osc_ded & ~standby;
	assign rst_in    = rst_ded & pin_in;

endmodule

`default_nettype wire

// ==== rtl/pin_state_defines.vh ====
// register offsets, field positions and reset values of the pin-state block
`ifndef PIN_STATE_DEFINES_VH
`define PIN_STATE_DEFINES_VH

`define OFS_STANDBY_CTRL   12'h000
`define OFS_DIRECTION      12'h004
`define OFS_DATA_OUT       12'h008
`define OFS_PULLUP         12'h00c
`define OFS_PERIPH_SEL     12'h010
`define OFS_EXTINT_EN      12'h014
`define OFS_PIN_LEVEL      12'h018
`define OFS_INT_STATUS     12'h01c
`define OFS_INT_MASK       12'h020

`define BIT_PIN_STATE_SEL  0
`define BIT_MAIN_OSC_EN    1
`define BIT_SUB_OSC_EN     2
`define BIT_RESET_PIN_EN   3
`define BIT_I2C_WAKE_EN    4
`define BIT_CMP_INT_EN     5
`define CTRL_WIDTH         6
`define CTRL_RESET         6'h08

`define EV_STANDBY_ENTRY   0
`define EV_STANDBY_EXIT    1
`define EV_I2C_WAKE        2
`define EV_EXTINT_WAKE     3
`define EV_WIDTH           4

`endif

// ==== rtl/pin_sync2.v ====
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 #(
	parameter WIDTH = 16
) (
	input  wire             pclk,    // system clock
	input  wire             presetn, // async reset, active low
	input  wire             ce,      // clock enable
	input  wire [WIDTH-1:0] d_async, // raw pin levels
	output wire [WIDTH-1:0] q_sync   // synchronised levels
);

	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_reg <= {WIDTH{1'b0}};
		end else if (ce) begin
			meta_reg <= d_async;
			sync_reg <= meta_reg;
		end
	end

	assign q_sync = sync_reg;

endmodule

`default_nettype wire

// ==== rtl/standby_pin_state_control.v ====
// pin-state control across run, sleep, stop, watch and reset, with apb registers
//
// Function
// - stop/watch: hold or float pins, block inputs
// - sleep leaves pins as in normal run
// - blocked input disables the digital input gate
// - port behaviour only when not dedicated function
// - main oscillator pins float in stop/watch
// - sub oscillator pins float in stop/watch
// - reset pin stays reset input always
// - reset: hi-z, input on except lcd pins
// - pull-up setting kept while floated, except on enabled oscillator pins
// - enabled external interrupts pass in standby
// - comparator output stays live when held
// - comparator analog input keeps working
// - i2c clock can wake from standby
// - floated pin input locked low
`timescale 1ns/1ps
`default_nettype none
`include "pin_state_defines.vh"

module standby_pin_state_control #(
	parameter NPINS       = 16,
	parameter MAIN_OSC    = 16'h0003, // main oscillator pin pair
	parameter SUB_OSC     = 16'h000c, // subclock oscillator pin pair
	parameter RESET_PIN   = 16'h0010, // shared reset pin
	parameter LCD_PINS    = 16'hf000, // lcd_segment_out / lcd_common_out pins
	parameter EXTINT_PINS = 16'h0f00, // external interrupt pins
	parameter CMP_OUT     = 16'h0020, // comparator_out_pin
	parameter CMP_IN      = 16'h0040, // comparator_in_pin
	parameter SCL_PIN     = 16'h0080  // i2c clock pin
) (
	input  wire             pclk,       // system clock, 25 MHz
	input  wire             presetn,    // cpu reset, async, active low
	input  wire             ce,         // clock enable, freezes all state
	input  wire             psel,       // apb select
	input  wire             penable,    // apb enable
	input  wire             pwrite,     // apb direction
	input  wire [11:0]      paddr,      // apb byte address
	input  wire [31:0]      pwdata,     // apb write data
	output wire [31:0]      prdata,     // apb read data
	output wire             pready,     // apb ready
	output wire             pslverr,    // apb error on unmapped address
	output wire             irq,        // level interrupt
	input  wire             stop_mode,  // chip in stop mode
	input  wire             watch_mode, // chip in watch mode
	input  wire [NPINS-1:0] periph_en,  // peripheral owns pin
	input  wire [NPINS-1:0] periph_oe,  // peripheral output enable
	input  wire [NPINS-1:0] periph_out, // peripheral output level
	input  wire             cmp_result, // live comparator result
	input  wire [NPINS-1:0] pin_in,     // pad input levels
	output wire [NPINS-1:0] pin_out,    // pad output levels
	output wire [NPINS-1:0] pin_oe,     // pad output enables
	output wire [NPINS-1:0] pin_pullup, // pad pull-up enables
	output wire [NPINS-1:0] pin_in_en,  // pad input gates open
	output wire [NPINS-1:0] port_in,    // gated levels to internal logic
	output wire [NPINS-1:0] extint_in,  // levels to interrupt detectors
	output wire [NPINS-1:0] analog_en,  // comparator analog paths open
	output wire [NPINS-1:0] osc_active, // oscillation inputs active
	output wire             rst_pin_in, // level from the reset pin
	output wire             wake        // standby wake request pulse
);

	////////////////////////////////////////////////////////////////
	// pin role masks, cut to the pin count on purpose

	localparam [NPINS-1:0] LCD_MASK = LCD_PINS[NPINS-1:0];
	localparam [NPINS-1:0] OSC_MASK = MAIN_OSC[NPINS-1:0] | SUB_OSC[NPINS-1:0];

	////////////////////////////////////////////////////////////////
	// registers

	reg [`CTRL_WIDTH-1:0] standby_control_reg;
	reg [NPINS-1:0]       direction_reg;
	reg [NPINS-1:0]       data_out_reg;
	reg [NPINS-1:0]       pullup_reg;
	reg [NPINS-1:0]       periph_sel_reg;
	reg [NPINS-1:0]       extint_en_reg;
	reg [`EV_WIDTH-1:0]   int_status_reg;
	reg [`EV_WIDTH-1:0]   int_mask_reg;
	reg [31:0]            prdata_reg;
	reg [31:0]            rdata_next;

	reg [NPINS-1:0]       held_oe_reg;
	reg [NPINS-1:0]       held_out_reg;
	reg [NPINS-1:0]       oe_reg;
	reg [NPINS-1:0]       out_reg;
	reg [NPINS-1:0]       pu_reg;
	reg [NPINS-1:0]       in_en_reg;
	reg [NPINS-1:0]       port_in_reg;
	reg [NPINS-1:0]       extint_reg;
	reg [NPINS-1:0]       analog_reg;
	reg [NPINS-1:0]       osc_reg;
	reg                   rst_in_reg;
	reg                   standby_reg;
	reg                   scl_prev_reg;
	reg [NPINS-1:0]       extint_prev_reg;
	reg                   wake_reg;

	wire [NPINS-1:0] pin_sync;
	wire [NPINS-1:0] cell_oe;
	wire [NPINS-1:0] cell_out;
	wire [NPINS-1:0] cell_pu;
	wire [NPINS-1:0] cell_in_en;
	wire [NPINS-1:0] cell_port_in;
	wire [NPINS-1:0] cell_extint;
	wire [NPINS-1:0] cell_analog;
	wire [NPINS-1:0] cell_scl;
	wire [NPINS-1:0] cell_osc;
	wire [NPINS-1:0] cell_rst;
	wire [NPINS-1:0] norm_oe;
	wire [NPINS-1:0] norm_out;
	wire [NPINS-1:0] osc_ded;
	wire [NPINS-1:0] rst_ded;

	// sleep behaves as run, so only stop and watch count
	wire standby   = stop_mode | watch_mode;
	wire pin_state_select       = standby_control_reg[`BIT_PIN_STATE_SEL];
	wire wr_stb    = psel & penable & pwrite & ce;
	wire setup_stb = psel & ~penable & ce;

	// unmapped decode for the error answer
	reg addr_ok;
	always @* begin
		if (paddr == `OFS_STANDBY_CTRL) begin
			addr_ok = 1'b1;
		end else if (paddr == `OFS_DIRECTION || paddr == `OFS_DATA_OUT || paddr == `OFS_PULLUP) begin
			addr_ok = 1'b1;
		end else if (paddr == `OFS_PERIPH_SEL || paddr == `OFS_EXTINT_EN || paddr == `OFS_PIN_LEVEL) begin
			addr_ok = 1'b1;
		end else if (paddr == `OFS_INT_STATUS || paddr == `OFS_INT_MASK) begin
			addr_ok = 1'b1;
		end else begin
			addr_ok = 1'b0;
		end
	end

	// read data is sampled in the setup cycle, so it comes from a flop
	always @* begin
		rdata_next = 32'h00000000;
		if (paddr == `OFS_STANDBY_CTRL) begin
			rdata_next[`CTRL_WIDTH-1:0] = standby_control_reg;
		end else if (paddr == `OFS_DIRECTION) begin
			rdata_next[NPINS-1:0] = direction_reg;
		end else if (paddr == `OFS_DATA_OUT) begin
			rdata_next[NPINS-1:0] = data_out_reg;
		end else if (paddr == `OFS_PULLUP) begin
			rdata_next[NPINS-1:0] = pullup_reg;
		end else if (paddr == `OFS_PERIPH_SEL) begin
			rdata_next[NPINS-1:0] = periph_sel_reg;
		end else if (paddr == `OFS_EXTINT_EN) begin
			rdata_next[NPINS-1:0] = extint_en_reg;
		end else if (paddr == `OFS_PIN_LEVEL) begin
			rdata_next[NPINS-1:0] = port_in_reg;
		end else if (paddr == `OFS_INT_STATUS) begin
			rdata_next[`EV_WIDTH-1:0] = int_status_reg;
		end else if (paddr == `OFS_INT_MASK) begin
			rdata_next[`EV_WIDTH-1:0] = int_mask_reg;
		end
	end

	assign prdata  = prdata_reg;
	// no wait states; a low clock enable stalls the bus
	assign pready  = ce;
	assign pslverr = psel & penable & ~addr_ok;

	////////////////////////////////////////////////////////////////
	// events

	wire scl_level   = |cell_scl;
	wire ev_entry    = standby & ~standby_reg;
	wire ev_exit     = ~standby & standby_reg;
	// gated by the enable: the masked clock would look like a falling edge on entry
	wire ev_i2c      = standby & i2c_wake_en & scl_prev_reg & ~scl_level;
	wire ev_extint   = standby & |(cell_extint & ~extint_prev_reg);
	wire [`EV_WIDTH-1:0] ev_vec;

	assign ev_vec[`EV_STANDBY_ENTRY] = ev_entry;
	assign ev_vec[`EV_STANDBY_EXIT]  = ev_exit;
	assign ev_vec[`EV_I2C_WAKE]      = ev_i2c;
	assign ev_vec[`EV_EXTINT_WAKE]   = ev_extint;

	assign irq  = |(int_status_reg & int_mask_reg);
	assign wake = wake_reg;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			standby_control_reg <= `CTRL_RESET;
			direction_reg       <= {NPINS{1'b0}};
			data_out_reg        <= {NPINS{1'b0}};
			pullup_reg          <= {NPINS{1'b0}};
			periph_sel_reg      <= {NPINS{1'b0}};
			extint_en_reg       <= {NPINS{1'b0}};
			int_status_reg      <= {`EV_WIDTH{1'b0}};
			int_mask_reg        <= {`EV_WIDTH{1'b0}};
			prdata_reg          <= 32'h00000000;
			standby_reg         <= 1'b0;
			scl_prev_reg        <= 1'b0;
			extint_prev_reg     <= {NPINS{1'b0}};
			wake_reg            <= 1'b0;
		end else if (ce) begin
			if (setup_stb && !pwrite) begin
				prdata_reg <= rdata_next;
			end
			if (wr_stb) begin
				if (paddr == `OFS_STANDBY_CTRL) begin
					standby_control_reg <= pwdata[`CTRL_WIDTH-1:0];
				end else if (paddr == `OFS_DIRECTION) begin
					direction_reg <= pwdata[NPINS-1:0];
				end else if (paddr == `OFS_DATA_OUT) begin
					data_out_reg <= pwdata[NPINS-1:0];
				end else if (paddr == `OFS_PULLUP) begin
					pullup_reg <= pwdata[NPINS-1:0];
				end else if (paddr == `OFS_PERIPH_SEL) begin
					periph_sel_reg <= pwdata[NPINS-1:0];
				end else if (paddr == `OFS_EXTINT_EN) begin
					extint_en_reg <= pwdata[NPINS-1:0];
				end else if (paddr == `OFS_INT_MASK) begin
					int_mask_reg <= pwdata[`EV_WIDTH-1:0];
				end
			end
			// set beats a same-cycle write-one clear
			if (wr_stb && paddr == `OFS_INT_STATUS) begin
				int_status_reg <= (int_status_reg & ~pwdata[`EV_WIDTH-1:0]) | ev_vec;
			end else begin
				int_status_reg <= int_status_reg | ev_vec;
			end
			standby_reg     <= standby;
			scl_prev_reg    <= scl_level;
			extint_prev_reg <= cell_extint;
			wake_reg        <= ev_i2c | ev_extint;
		end
	end

	////////////////////////////////////////////////////////////////
	// pin cells

	pin_sync2 #(
		.WIDTH (NPINS)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.d_async (pin_in),
		.q_sync  (pin_sync)
	);

	wire main_osc_en  = standby_control_reg[`BIT_MAIN_OSC_EN];
	wire sub_osc_en   = standby_control_reg[`BIT_SUB_OSC_EN];
	wire reset_pin_en = standby_control_reg[`BIT_RESET_PIN_EN];
	wire i2c_wake_en  = standby_control_reg[`BIT_I2C_WAKE_EN];

	genvar i;
	generate
		for (i = 0; i < NPINS; i = i + 1) begin : g_pin
			assign osc_ded[i]  = (MAIN_OSC[i] & main_osc_en) | (SUB_OSC[i] & sub_osc_en);
			assign rst_ded[i]  = RESET_PIN[i] & reset_pin_en;
			assign norm_oe[i]  = periph_sel_reg[i] & periph_en[i] ? periph_oe[i] : direction_reg[i];
			assign norm_out[i] = periph_sel_reg[i] & periph_en[i] ? periph_out[i] : data_out_reg[i];

			pin_state_cell u_cell (
				.standby     (standby),
				.pin_state_select         (pin_state_select),
				.osc_ded     (osc_ded[i]),
				.rst_ded     (rst_ded[i]),
				.is_cmp_out  (CMP_OUT[i] ? 1'b1 : 1'b0),
				.is_extint   (EXTINT_PINS[i] ? 1'b1 : 1'b0),
				.extint_en   (extint_en_reg[i]),
				.is_cmp_in   (CMP_IN[i] ? 1'b1 : 1'b0),
				.is_scl      (SCL_PIN[i] ? 1'b1 : 1'b0),
				.i2c_wake_en (i2c_wake_en),
				.norm_oe     (norm_oe[i]),
				.norm_out    (norm_out[i]),
				.held_oe     (held_oe_reg[i]),
				.held_out    (held_out_reg[i]),
				.cmp_result  (cmp_result),
				.pu_set      (pullup_reg[i]),
				.pin_in      (pin_sync[i]),
				.oe          (cell_oe[i]),
				.out         (cell_out[i]),
				.pu          (cell_pu[i]),
				.in_en       (cell_in_en[i]),
				.port_in     (cell_port_in[i]),
				.extint_in   (cell_extint[i]),
				.analog_en   (cell_analog[i]),
				.scl_in      (cell_scl[i]),
				.osc_act     (cell_osc[i]),
				.rst_in      (cell_rst[i])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// pad registers; reset state is hi-z, input open except lcd pins

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held_oe_reg  <= {NPINS{1'b0}};
			held_out_reg <= {NPINS{1'b0}};
			oe_reg       <= {NPINS{1'b0}};
			out_reg      <= {NPINS{1'b0}};
			pu_reg       <= {NPINS{1'b0}};
			in_en_reg    <= ~LCD_MASK;
			port_in_reg  <= {NPINS{1'b0}};
			extint_reg   <= {NPINS{1'b0}};
			analog_reg   <= {NPINS{1'b0}};
			osc_reg      <= OSC_MASK;
			rst_in_reg   <= 1'b0;
		end else if (ce) begin
			// track the drive in every run cycle, so the value held in
			// standby is the last one driven, even right after an exit
			if (!standby) begin
				held_oe_reg  <= cell_oe;
				held_out_reg <= cell_out;
			end
			oe_reg      <= cell_oe;
			out_reg     <= cell_out;
			pu_reg      <= cell_pu;
			in_en_reg   <= cell_in_en;
			port_in_reg <= cell_port_in;
			extint_reg  <= cell_extint;
			analog_reg  <= cell_analog;
			osc_reg     <= cell_osc;
			rst_in_reg  <= |cell_rst;
		end
	end

	assign pin_oe     = oe_reg;
	assign pin_out    = out_reg;
	assign pin_pullup = pu_reg;
	assign pin_in_en  = in_en_reg;
	assign port_in    = port_in_reg;
	assign extint_in  = extint_reg;
	assign analog_en  = analog_reg;
	assign osc_active = osc_reg;
	assign rst_pin_in = rst_in_reg;

endmodule

`default_nettype wire
